/* File: common/msrm_regs.svh */
`ifndef MSRM_REGS_SVH
`define MSRM_REGS_SVH

// Function codes served by the slave.
`define MS_FN_RD_HOLD  8'h03
`define MS_FN_RD_INPUT 8'h04
`define MS_FN_WR_ONE   8'h06
`define MS_FN_EXC_STAT 8'h07
`define MS_FN_WR_MULTI 8'h10
`define MS_FN_SLAVE_ID 8'h11

// Exception codes carried in the low byte of an exception answer.
`define MS_EXC_FUNC 8'h01
`define MS_EXC_ADDR 8'h02
`define MS_EXC_VAL  8'h03

// Slave address limits.
`define MS_ADDR_BCAST 8'h00
`define MS_ADDR_MIN   8'h01
`define MS_ADDR_MAX   8'hf7

// Holding register map.
`define MS_HR_ALT   7'h00
`define MS_HR_HEAT  7'h01
`define MS_HR_RST   7'h02
`define MS_HR_COUNT 16'h0003

// Input register map.
`define MS_IR_ID    7'h00
`define MS_IR_FAULT 7'h01
`define MS_IR_SENS1 7'h02
`define MS_IR_SENS2 7'h03
`define MS_IR_RSV_A 7'h04
`define MS_IR_RSV_E 7'h08
`define MS_IR_RUN   7'h09
`define MS_IR_COUNT 16'h007d

// Quantity limits per request.
`define MS_RD_MAX_QTY 16'h007d
`define MS_WR_MAX_QTY 16'h007b

// Holding register values and plausibility limits.
`define MS_ALT_RST   16'h0000
`define MS_ALT_MIN   16'hff9c
`define MS_ALT_MAX   16'h1388
`define MS_HEAT_RST  16'h0100
`define MS_OPM_MAX   8'h04
`define MS_PWR_MAX   8'h01
`define MS_OPM_OFF   8'h00
`define MS_OPM_TEST  8'h02
`define MS_OPM_OFFHI 8'h03
`define MS_OPM_OFFLO 8'h04
`define MS_RST_MAGIC 16'h3247

// Measurement word limits and error values.
`define MS_U_MAX  32'h0000fffa
`define MS_S_MAX  32'h00007ffa
`define MS_S_MIN  32'hffff8006
`define MS_U_ERR  16'hffff
`define MS_S_ERR  16'h7fff
`define MS_UP_SAT 16'hfffa

// Identification answer and link defaults.
`define MS_ID_RUN 8'hff
`define MS_BAUD   16'h4b00

// Run time step.
`define MS_RUN_STEP_S 10
`define MS_CLK_HZ     25000000
`define MS_TICK_W     28

`endif

/* File: common/msrm_pkg.sv */
package msrm_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RD   = 4'h2,
        ST_WR   = 4'h4,
        ST_DONE = 4'h8
    } msrm_state_t;

    // Four-bit sensor status codes.
    typedef enum logic [3:0] {
        SS_OK                   = 4'h0,
        SS_INVALID_CHANNEL_CODE = 4'h1,
        SS_STORAGE              = 4'h2,
        SS_MEAS_ERR             = 4'h3,
        SS_CANNOT_MEASURE_CODE  = 4'h4,
        SS_INIT                 = 4'h5,
        SS_OVER                 = 4'h6,
        SS_UNDER                = 4'h7,
        SS_BUSY                 = 4'h8,
        SS_OTHER                = 4'h9
    } msrm_status_t;

    typedef struct packed {
        logic [7:0]  unit;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] qty;
    } msrm_req_t;

    typedef struct packed {
        logic        exc;
        logic        last;
        logic [15:0] data;
    } msrm_rsp_t;

    typedef struct packed {
        logic [3:0] tbuf;
        logic [3:0] temp;
        logic [3:0] pbuf;
        logic [3:0] pres;
        logic [3:0] wbuf;
        logic [3:0] wind;
    } msrm_sens_t;

    typedef struct packed {
        msrm_state_t st;
        logic [15:0] alt;
        logic [15:0] heat;
        logic [7:0]  func;
        logic [15:0] qty;
        logic [6:0]  ptr;
        logic [6:0]  cnt;
        logic [27:0] tick;
        logic [15:0] up;
        logic [1:0]  sync;
        logic        hon;
        logic        rst;
        logic        rv;
        msrm_rsp_t   rsp;
    } msrm_ctx_t;

endpackage

/* File: core/msrm_slave.sv */
// Summary of operation
// - Slave address follows native address, 1..247.
// - Native address above 247 clamps to 247.
// - Serve read holding, read input, write single.
// - Accept write multiple registers, code 0x10.
// - Exception status always answers zero.
// - Slave ID answered also on broadcast.
// - Holding 0 holds altitude, -100..5000 metres.
// - Heating high byte selects operating mode 0..4.
// - Heating low byte selects full/alternating power.
// - Heating word is power plus 256 times mode.
// - Holding 2 acts on writes, reads zero.
// - Writing 0x3247 to holding 2 resets device.
// - Implausible word rejected, unchanged, with exception; earlier words of a write multiple stay written.
// - Measurements limited to 16-bit scaled ranges.
// - Bad measurement reads 0xffff or 32767.
// - Input register space spans addresses 0..124.
// - Same map for all subtypes; missing gives error.
// - Input 0: subtype high, software version low.
// - Input 1 nonzero on storage or start-up fault.
// - Input 2 packs four temperature/pressure status nibbles.
// - Input 3 high byte holds wind status nibbles.
// - Input 9 reports run time in ten seconds.
// - Status codes 0..9, anything else reads 9.
// - Link defaults to 19200 baud, even parity.
`include "msrm_regs.svh"

module msrm_slave
    import msrm_pkg::*;
#(
    parameter int TICK_CYCLES = `MS_RUN_STEP_S * `MS_CLK_HZ
) (
    input  wire logic        clk,          // System clock, 25 MHz.
    input  wire logic        resetn,       // Asynchronous reset, active low.
    input  wire logic [7:0]  native_protocol_address, // Configured native address.
    input  wire logic        req_valid,    // Decoded request present.
    output logic             req_ready,    // Request taken this cycle.
    input  wire msrm_req_t   req,          // Unit, function, address, quantity or value.
    input  wire logic        wr_valid,     // Write-multiple data word present.
    output logic             wr_ready,     // Write-multiple data word taken.
    input  wire logic [15:0] wr_data,      // Write-multiple data word.
    output logic             rsp_valid,    // Answer word present.
    input  wire logic        rsp_ready,    // Answer word accepted.
    output msrm_rsp_t        rsp,          // Answer word, exception flag and last flag.
    input  wire logic [7:0]  subtype,      // Device subtype.
    input  wire logic [7:0]  sw_version,   // Software version.
    input  wire logic [15:0] fault_code,   // Configuration or start-up fault code.
    input  wire msrm_sens_t  sens,         // Sensor status nibbles.
    output logic [6:0]       ext_addr,     // Measurement register being fetched.
    input  wire logic signed [31:0] ext_raw, // Measurement value, already scaled.
    input  wire logic        ext_ok,       // Measurement value available.
    input  wire logic        ext_signed,   // Measurement register is signed.
    input  wire logic        ctrl_line,    // External heating control line pin.
    output logic             heat_on,      // Heating allowed.
    output logic             heat_alt,     // Alternating reduced power.
    output logic             heat_test,    // Maintenance test mode.
    output logic             dev_reset,    // One-cycle device reset request.
    output logic [7:0]       slave_addr,   // Effective slave address.
    output logic [15:0]      link_baud,    // Default link rate in baud.
    output logic             link_even     // Default even parity.
);

    localparam logic [27:0] TICK_LAST = `MS_TICK_W'(TICK_CYCLES - 1);

    localparam msrm_ctx_t CTX_RST = '{
        st:   ST_IDLE,
        alt:  `MS_ALT_RST,
        heat: `MS_HEAT_RST,
        default: '0
    };

    // Refuse a run-time step that the tick counter cannot hold.
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << `MS_TICK_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    msrm_ctx_t   q;
    msrm_ctx_t   s;
    logic [6:0]  fetch;
    logic        wr_try;
    logic [6:0]  wr_a;
    logic [15:0] wr_d;
    logic [15:0] lim;

    // Effective slave address, clamped into the valid range.
    function automatic logic [7:0] eff_addr(input logic [7:0] na);
        if (na < `MS_ADDR_MIN) begin
            return `MS_ADDR_MIN;
        end
        if (na > `MS_ADDR_MAX) begin
            return `MS_ADDR_MAX;
        end
        return na;
    endfunction

    // Status nibble, with unknown codes folded into the catch-all code.
    function automatic logic [3:0] norm(input logic [3:0] c);
        return (c > SS_OTHER) ? SS_OTHER : c;
    endfunction

    // Scaled measurement limited to the 16-bit word or replaced by the error value.
    function automatic logic [15:0] scale(input logic signed [31:0] v, input logic ok, input logic sgn);
        if (!ok) begin
            return sgn ? `MS_S_ERR : `MS_U_ERR;
        end
        if (sgn) begin
            if (v > $signed(`MS_S_MAX)) return 16'(`MS_S_MAX);
            if (v < $signed(`MS_S_MIN)) return 16'(`MS_S_MIN);
            return v[15:0];
        end
        if (v < 0) return 16'h0000;
        if (v > $signed(`MS_U_MAX)) return 16'(`MS_U_MAX);
        return v[15:0];
    endfunction

    // Plausibility check of a holding register write.
    function automatic logic plaus(input logic [6:0] a, input logic [15:0] d);
        case (a)
            `MS_HR_ALT: begin
                return $signed(d) >= $signed(`MS_ALT_MIN) && $signed(d) <= $signed(`MS_ALT_MAX);
            end
            `MS_HR_HEAT: begin
                return d[15:8] <= `MS_OPM_MAX && d[7:0] <= `MS_PWR_MAX;
            end
            `MS_HR_RST: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    // Register word for one address of either map.
    function automatic logic [15:0] rd_word(input logic inp, input logic [6:0] a);
        if (!inp) begin
            case (a)
                `MS_HR_ALT:  return q.alt;
                `MS_HR_HEAT: return q.heat;
                default:     return 16'h0000;
            endcase
        end
        case (a)
            `MS_IR_ID:    return {subtype, sw_version};
            `MS_IR_FAULT: return fault_code;
            `MS_IR_SENS1: return {norm(sens.tbuf), norm(sens.temp), norm(sens.pbuf), norm(sens.pres)};
            `MS_IR_SENS2: return {norm(sens.wbuf), norm(sens.wind), 8'h00};
            `MS_IR_RUN:   return q.up;
            default: begin
                if (a >= `MS_IR_RSV_A && a <= `MS_IR_RSV_E) begin
                    return 16'h0000;
                end
                return scale(ext_raw, ext_ok, ext_signed);
            end
        endcase
    endfunction

    // Next-state logic: request decode, word streaming, writes and run time.
    always_comb begin
        s         = q;
        wr_ready  = 1'b0;
        wr_try    = 1'b0;
        wr_a      = 7'h00;
        wr_d      = 16'h0000;
        lim       = `MS_HR_COUNT;
        fetch     = q.ptr + 7'h01;
        s.rst     = 1'b0;
        s.sync    = {q.sync[0], ctrl_line};
        if (q.tick == TICK_LAST) begin
            s.tick = '0;
            s.up   = (q.up == `MS_UP_SAT) ? q.up : q.up + 16'h0001;
        end else begin
            s.tick = q.tick + 28'h0000001;
        end
        case (q.st)
            ST_IDLE: begin
                fetch = req.addr[6:0];
                if (req_valid) begin
                    s.func     = req.func;
                    s.qty      = req.qty;
                    s.ptr      = req.addr[6:0];
                    s.cnt      = req.qty[6:0];
                    s.rsp      = '0;
                    s.rsp.last = 1'b1;
                    if (req.unit == eff_addr(native_protocol_address) ||
                        (req.unit == `MS_ADDR_BCAST && req.func == `MS_FN_SLAVE_ID)) begin
                        s.st = ST_DONE;
                        s.rv = 1'b1;
                        case (req.func)
                            `MS_FN_RD_HOLD, `MS_FN_RD_INPUT: begin
                                lim = (req.func == `MS_FN_RD_INPUT) ? `MS_IR_COUNT : `MS_HR_COUNT;
                                if (req.qty == 16'h0000 || req.qty > `MS_RD_MAX_QTY) begin
                                    s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_VAL}};
                                end else if (req.addr >= lim || req.qty > lim - req.addr) begin
                                    s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_ADDR}};
                                end else begin
                                    s.st       = ST_RD;
                                    s.rsp.data = rd_word(req.func == `MS_FN_RD_INPUT, fetch);
                                    s.rsp.last = (req.qty == 16'h0001);
                                end
                            end
                            `MS_FN_WR_ONE: begin
                                if (req.addr >= `MS_HR_COUNT) begin
                                    s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_ADDR}};
                                end else begin
                                    wr_try = 1'b1;
                                    wr_a   = req.addr[6:0];
                                    wr_d   = req.qty;
                                    if (plaus(wr_a, wr_d)) begin
                                        s.rsp.data = req.qty;
                                    end else begin
                                        s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_VAL}};
                                    end
                                end
                            end
                            `MS_FN_WR_MULTI: begin
                                if (req.qty == 16'h0000 || req.qty > `MS_WR_MAX_QTY) begin
                                    s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_VAL}};
                                end else if (req.addr >= `MS_HR_COUNT || req.qty > `MS_HR_COUNT - req.addr) begin
                                    s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_ADDR}};
                                end else begin
                                    s.st = ST_WR;
                                    s.rv = 1'b0;
                                end
                            end
                            `MS_FN_EXC_STAT: begin
                                s.rsp.data = 16'h0000;
                            end
                            `MS_FN_SLAVE_ID: begin
                                s.rsp.data = {subtype, `MS_ID_RUN};
                            end
                            default: begin
                                s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_FUNC}};
                            end
                        endcase
                    end
                end
            end
            ST_RD: begin
                if (rsp_ready) begin
                    if (q.rsp.last) begin
                        s.st = ST_IDLE;
                        s.rv = 1'b0;
                    end else begin
                        s.ptr      = fetch;
                        s.cnt      = q.cnt - 7'h01;
                        s.rsp.data = rd_word(q.func == `MS_FN_RD_INPUT, fetch);
                        s.rsp.last = (q.cnt == 7'h02);
                    end
                end
            end
            ST_WR: begin
                wr_ready = 1'b1;
                if (wr_valid) begin
                    wr_try = 1'b1;
                    wr_a   = q.ptr;
                    wr_d   = wr_data;
                    if (!plaus(wr_a, wr_d)) begin
                        s.st  = ST_DONE;
                        s.rv  = 1'b1;
                        s.rsp = '{exc: 1'b1, last: 1'b1, data: {8'h00, `MS_EXC_VAL}};
                    end else if (q.cnt == 7'h01) begin
                        s.st  = ST_DONE;
                        s.rv  = 1'b1;
                        s.rsp = '{exc: 1'b0, last: 1'b1, data: q.qty};
                    end else begin
                        s.ptr = fetch;
                        s.cnt = q.cnt - 7'h01;
                    end
                end
            end
            ST_DONE: begin
                if (rsp_ready) begin
                    s.st = ST_IDLE;
                    s.rv = 1'b0;
                end
            end
            default: begin
                s.st = ST_IDLE;
                s.rv = 1'b0;
            end
        endcase
        // Accepted writes update the holding registers; rejected ones leave them alone.
        if (wr_try && plaus(wr_a, wr_d)) begin
            case (wr_a)
                `MS_HR_ALT:  s.alt = wr_d;
                `MS_HR_HEAT: s.heat = wr_d;
                `MS_HR_RST:  s.rst = (wr_d == `MS_RST_MAGIC);
                default:     s.alt = q.alt;
            endcase
        end
        // Heating permission from the operating mode and the synchronised control line.
        case (q.heat[15:8])
            `MS_OPM_OFF:   s.hon = 1'b0;
            `MS_OPM_OFFHI: s.hon = !q.sync[1];
            `MS_OPM_OFFLO: s.hon = q.sync[1];
            default:       s.hon = 1'b1;
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= CTX_RST;
        end else begin
            q <= s;
        end
    end

    // Outputs from the state register, except ext_addr, slave_addr and the link constants.
    assign req_ready  = (q.st == ST_IDLE);
    assign rsp_valid  = q.rv;
    assign rsp        = q.rsp;
    assign ext_addr   = fetch;
    assign heat_on    = q.hon;
    assign heat_alt   = q.heat[0];
    assign heat_test  = (q.heat[15:8] == `MS_OPM_TEST);
    assign dev_reset  = q.rst;
    assign slave_addr = eff_addr(native_protocol_address);
    assign link_baud  = `MS_BAUD;
    assign link_even  = 1'b1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Address handling.
    chk_addr_clamp: assert property (
        native_protocol_address > `MS_ADDR_MAX |-> slave_addr == `MS_ADDR_MAX)
        else $error("slave address not clamped");

    chk_addr_range: assert property (
        slave_addr >= `MS_ADDR_MIN && slave_addr <= `MS_ADDR_MAX)
        else $error("slave address out of range");

    // Holding register writes and the restart trigger.
    chk_reset_magic: assert property (
        wr_try && wr_a == `MS_HR_RST && wr_d == `MS_RST_MAGIC |=> dev_reset ##1 !dev_reset)
        else $error("reset trigger missing");

    chk_reject_keeps: assert property (
        wr_try && !plaus(wr_a, wr_d) |=> $stable(q.alt) && $stable(q.heat) && rsp_valid && rsp.exc)
        else $error("implausible write changed state");

    chk_heat_fields: assert property (
        q.heat[15:8] <= `MS_OPM_MAX && q.heat[7:0] <= `MS_PWR_MAX && heat_alt == q.heat[0])
        else $error("heating word malformed");

    chk_alt_bounds: assert property (
        $signed(q.alt) >= $signed(`MS_ALT_MIN) && $signed(q.alt) <= $signed(`MS_ALT_MAX))
        else $error("altitude out of range");

    // Answers to reads and to the simple functions.
    chk_hold2_zero: assert property (
        q.st == ST_RD && q.func == `MS_FN_RD_HOLD && q.ptr == `MS_HR_RST |-> rsp.data == 16'h0000)
        else $error("reset register read nonzero");

    chk_unsup_func: assert property (
        req_valid && req_ready && req.unit == slave_addr && req.func == 8'h01
        |=> rsp_valid && rsp.exc && rsp.data[7:0] == `MS_EXC_FUNC)
        else $error("unsupported function not refused");

    chk_excstat_zero: assert property (
        req_valid && req_ready && req.unit == slave_addr && req.func == `MS_FN_EXC_STAT
        |=> rsp_valid && !rsp.exc && rsp.data == 16'h0000)
        else $error("exception status nonzero");

    chk_bcast_ident: assert property (
        req_valid && req_ready && req.unit == `MS_ADDR_BCAST && req.func == `MS_FN_SLAVE_ID
        |=> rsp_valid && !rsp.exc && rsp.data[7:0] == `MS_ID_RUN)
        else $error("broadcast identification unanswered");

    // Run time counter.
    chk_uptime_step: assert property (
        q.tick == TICK_LAST && q.up != `MS_UP_SAT |=> q.up == $past(q.up) + 16'h0001)
        else $error("run time did not advance");

    // Main scenarios to be reached.

    cov_rd_input: cover property (q.st == ST_RD && q.func == `MS_FN_RD_INPUT && rsp_ready && rsp.last);
    cov_wr_multi: cover property (q.st == ST_WR ##1 q.st == ST_WR ##[1:8] q.st == ST_DONE && !rsp.exc);
    cov_dev_reset: cover property (dev_reset);
    cov_bcast_id: cover property (req_valid && req_ready && req.unit == `MS_ADDR_BCAST && req.func == `MS_FN_SLAVE_ID);
    cov_clamp: cover property (native_protocol_address > `MS_ADDR_MAX);

endmodule

/* File: dv/msrm_master.sv */
module msrm_master
    import msrm_pkg::*;
(
    input  wire logic      clk,       // Clock.
    output msrm_req_t      req,       // Request.
    output logic           req_valid, // Request present.
    input  wire logic      req_ready, // Request taken.
    output logic [15:0]    wr_data,   // Data word.
    output logic           wr_valid,  // Word present.
    input  wire logic      wr_ready,  // Word taken.
    input  wire msrm_rsp_t rsp,       // Answer word.
    input  wire logic      rsp_valid, // Answer present.
    output logic           rsp_ready  // Answer taken.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] wq[$];
    msrm_rsp_t   rq[$];
    logic        slow = 1'b0;
    logic        hung = 1'b0;
    // All lines idle at time zero, except rsp_ready, which starts high.
    initial begin
        req = '0;
        req_valid = 1'b0;
        wr_data = 16'h0000;
        wr_valid = 1'b0;
        rsp_ready = 1'b1;
    end
    // Hold a request until taken, feed words, gather answers; released lines flip.
    task automatic run(input msrm_req_t r, input int lim);
        int   k;
        logic done;
        done = 1'b0;
        rq.delete();
        @(posedge clk);
        #1;
        req = r;
        req_valid = 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!req_ready && k < 20);
        for (k = 0; k < lim && !done; k++) begin
            #1;
            req_valid = 1'b0;
            req = ~r;
            wr_valid = wq.size() > 0;
            wr_data = wq.size() > 0 ? wq[0] : ~wr_data;
            rsp_ready = slow ? ~rsp_ready : 1'b1;
            @(posedge clk);
            if (wr_valid && wr_ready) void'(wq.pop_front());
            if (rsp_valid && rsp_ready) begin
                rq.push_back(rsp);
                done = rsp.last;
            end
        end
        #1;
        wr_valid = 1'b0;
        wr_data = ~wr_data;
        rsp_ready = 1'b1;
        wq.delete();
        if (lim > 50 && !done) hung = 1'b1;
    endtask
endmodule

/* File: dv/msrm_slave_tb_top.sv */
module msrm_slave_tb_top
    import msrm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    logic [7:0]         native_protocol_address = 8'h05;
    logic               ext_ok = 1'b0;
    logic               ext_signed = 1'b0;
    logic               ctrl_line = 1'b1;
    logic signed [31:0] ext_raw = '0;
    msrm_sens_t         sens = 24'h123456;
    logic [7:0]         un = 8'h05;
    logic [15:0]        v, t0;
    int                 failures = 0, n_checks = 0, n_rst = 0, i;
    msrm_req_t          req;
    msrm_rsp_t          rsp;
    logic               req_valid, req_ready, wr_valid, wr_ready, rsp_valid, rsp_ready;
    logic               heat_on, heat_alt, heat_test, dev_reset, link_even;
    logic [15:0]        wr_data, link_baud, av[4], xe[4];
    logic [7:0]         slave_addr, fc[3];
    logic [6:0]         ext_addr;
    logic [17:0]        ev[5];
    logic [33:0]        xt[4];
    msrm_slave #(.TICK_CYCLES(16)) dut (.clk, .resetn, .native_protocol_address, .req_valid, .req_ready,
        .req, .wr_valid, .wr_ready, .wr_data, .rsp_valid, .rsp_ready, .rsp, .subtype(8'h2a),
        .sw_version(8'h13), .fault_code(16'h00c5), .sens, .ext_addr, .ext_raw, .ext_ok, .ext_signed,
        .ctrl_line, .heat_on, .heat_alt, .heat_test, .dev_reset, .slave_addr, .link_baud, .link_even);
    msrm_master m (.clk, .req, .req_valid, .req_ready, .wr_data, .wr_valid, .wr_ready, .rsp, .rsp_valid,
        .rsp_ready);
    // Free-running clock and a count of reset pulses.
    always #20 clk = ~clk;
    always @(posedge clk) if (dev_reset === 1'b1) n_rst++;
    function automatic logic [17:0] ok(input logic l, input logic [15:0] d);
        return {1'b0, l, d};
    endfunction
    function automatic logic [17:0] ex(input logic [7:0] c);
        return {10'h300, c};
    endfunction
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [17:0] e, input logic [17:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tx(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q, input int lim = 300);
        m.run({un, f, a, q}, lim);
        if (m.hung) begin
            failures++;
            wrap_up();
        end
    endtask
    // Main sequence of transfers with expected answers.
    initial begin
        av = '{16'h1389, 16'hff9c, 16'hff9b, 16'h1388};
        xt = '{{2'b00, 32'h0}, {2'b01, 32'h0}, {2'b10, 32'd70000}, {2'b11, -32'sd40000}};
        xe = '{16'hffff, 16'h7fff, 16'hfffa, 16'h8006};
        fc = '{8'h01, 8'h16, 8'h05};
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        chk("addr", 18'(8'h05), 18'(slave_addr));
        chk("link", {2'b01, 16'h4b00}, {1'b0, link_even, link_baud});
        tx(8'h03, 16'h0000, 16'h0003);
        for (i = 0; i < 3; i++) chk("hold", ok(i == 2, i == 1 ? 16'h0100 : 16'h0000), m.rq[i]);
        foreach (av[j]) begin
            tx(8'h06, 16'h0000, av[j]);
            chk("alt", j[0] ? ok(1, av[j]) : ex(8'h03), m.rq[0]);
        end
        m.wq = '{16'h0064, 16'h0101};
        tx(8'h10, 16'h0000, 16'h0002);
        chk("multi", ok(1, 16'h0002), m.rq[0]);
        m.wq = '{16'h0005, 16'h0500};
        tx(8'h10, 16'h0000, 16'h0002);
        chk("multi bad", ex(8'h03), m.rq[0]);
        tx(8'h03, 16'h0000, 16'h0003);
        ev = '{ok(0, 16'h0005), ok(0, 16'h0101), ok(1, 16'h0000), 0, 0};
        for (i = 0; i < 3; i++) chk("hold", ev[i], m.rq[i]);
        tx(8'h03, 16'h0000, 16'h0004);
        chk("hold span", ex(8'h02), m.rq[0]);
        tx(8'h06, 16'h0002, 16'h1234);
        tx(8'h06, 16'h0002, 16'h3247);
        repeat (2) @(posedge clk);
        chk("restart", 18'd1, 18'(n_rst));
        for (i = 0; i < 6; i++) begin
            v = 16'(i % 2 + 256 * i);
            tx(8'h06, 16'h0001, v);
            chk("heat", i < 5 ? ok(1, v) : ex(8'h03), m.rq[0]);
            repeat (2) @(posedge clk);
            t0 = 16'(i < 5 ? i : 4);
            chk("heat out", 18'({t0 inside {1, 2, 4}, t0[0], t0 == 2}), 18'({heat_on, heat_alt, heat_test}));
        end
        #1 ctrl_line = 1'b0;
        repeat (4) @(posedge clk);
        chk("heat low", 18'd0, 18'(heat_on));
        m.slow = 1'b1;
        tx(8'h04, 16'h0000, 16'h0005);
        m.slow = 1'b0;
        ev = '{ok(0, 16'h2a13), ok(0, 16'h00c5), ok(0, 16'h1234), ok(0, 16'h5600), ok(1, 16'h0000)};
        foreach (ev[j]) chk("input", ev[j], m.rq[j]);
        foreach (xe[j]) begin
            {ext_ok, ext_signed, ext_raw} = xt[j];
            tx(8'h04, 16'h000a, 16'h0001);
            chk("meas", ok(1, xe[j]), m.rq[0]);
        end
        tx(8'h04, 16'h007b, 16'h0002);
        chk("top", ok(1, 16'h8006), m.rq[1]);
        tx(8'h04, 16'h007c, 16'h0002);
        chk("beyond", ex(8'h02), m.rq[0]);
        tx(8'h04, 16'h0000, 16'h0000);
        chk("qty0", ex(8'h03), m.rq[0]);
        foreach (fc[j]) begin
            tx(fc[j], 16'h0000, 16'h0001);
            chk("func", ex(8'h01), m.rq[0]);
        end
        tx(8'h07, 16'h0000, 16'h0000);
        chk("exc stat", ok(1, 16'h0000), m.rq[0]);
        un = 8'h00;
        tx(8'h11, 16'h0000, 16'h0000);
        chk("ident", ok(1, 16'h2aff), m.rq[0]);
        tx(8'h07, 16'h0000, 16'h0000, 8);
        chk("bcast", 18'd0, 18'(m.rq.size()));
        un = 8'h06;
        tx(8'h07, 16'h0000, 16'h0000, 8);
        chk("other", 18'd0, 18'(m.rq.size()));
        native_protocol_address = 8'hff;
        un = 8'hf7;
        tx(8'h07, 16'h0000, 16'h0000);
        chk("clamp", ok(1, 16'h00f7), {m.rq[0].exc, m.rq[0].last, 8'h00, slave_addr});
        tx(8'h04, 16'h0009, 16'h0001);
        t0 = m.rq[0].data;
        repeat (160) @(posedge clk);
        tx(8'h04, 16'h0009, 16'h0001);
        v = m.rq[0].data - t0;
        chk("run", 18'd1, 18'(v >= 16'd9 && v <= 16'd11));
        wrap_up();
    end
endmodule
